/* hdl/spk_pkg.sv */
package spk_pkg;

    // register indices on the plain register port
    localparam int SPK_ADDR_W = 4;
    localparam logic [3:0] SPK_REG_CTRL = 4'h0;
    localparam logic [3:0] SPK_REG_DELIM = 4'h1;
    localparam logic [3:0] SPK_REG_TIMEOUT = 4'h2;
    localparam logic [3:0] SPK_REG_PKTLEN = 4'h3;
    localparam logic [3:0] SPK_REG_STATUS = 4'h4;
    localparam logic [3:0] SPK_REG_FRAMES = 4'h5;

    // register field positions
    localparam int SPK_CTRL_MATCH2_BIT = 0;
    localparam int SPK_CTRL_TRAIL_LSB = 1;
    localparam int SPK_DELIM1_LSB = 0;
    localparam int SPK_DELIM2_LSB = 8;
    localparam int SPK_STATUS_DRAIN_BIT = 16;
    localparam int SPK_STATUS_CAUSE_LSB = 20;

    // sizes
    localparam int SPK_DEPTH = 1024;
    localparam int SPK_TIMEOUT_W = 16;
    localparam int SPK_LEN_W = 11;

    // reset values
    localparam logic SPK_RST_MATCH2 = 1'b1;
    localparam logic [1:0] SPK_RST_TRAIL = 2'h0;
    localparam logic [7:0] SPK_RST_DELIM = 8'h00;
    localparam logic [15:0] SPK_RST_TIMEOUT = 16'h0000;
    localparam logic [10:0] SPK_RST_PKTLEN = 11'h000;

    // trailing byte selections
    localparam logic [1:0] SPK_TRAIL_NONE = 2'h0;
    localparam logic [1:0] SPK_TRAIL_ONE = 2'h1;
    localparam logic [1:0] SPK_TRAIL_TWO = 2'h2;

    // reasons a buffer was closed
    localparam logic [2:0] SPK_CAUSE_NONE = 3'h0;
    localparam logic [2:0] SPK_CAUSE_DELIM = 3'h1;
    localparam logic [2:0] SPK_CAUSE_TIMEOUT = 3'h2;
    localparam logic [2:0] SPK_CAUSE_LENGTH = 3'h3;
    localparam logic [2:0] SPK_CAUSE_FULL = 3'h4;
    localparam logic [2:0] SPK_CAUSE_PASS = 3'h5;

    typedef enum logic [0:0] {SPK_ACCUM, SPK_DRAIN} spk_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } spk_beat_s;

endpackage : spk_pkg

/* hdl/spk_delim_match.sv */
`timescale 1ns/1ps
module spk_delim_match import spk_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    input wire logic clear,
    input wire logic [7:0] delim1,
    input wire logic [7:0] delim2,
    input wire logic matchTwo,
    output logic hit
);
    typedef struct packed {
        logic sawFirst;
    } spk_match_s;

    spk_match_s q;
    spk_match_s d;
    logic en1;
    logic en2;

    always_comb
    begin
        d = q;
        en1 = (delim1 != 8'h00);
        en2 = (delim2 != 8'h00);
        if (en1 && en2 && matchTwo)
        begin
            // only the first delimiter directly followed by the second counts
            hit = byteValid && q.sawFirst && (byteData == delim2);
        end
        else
        begin
            hit = byteValid && ((en1 && byteData == delim1) ||
                (en2 && byteData == delim2));
        end
        if (clear)
            d.sawFirst = 1'b0;
        else if (byteValid)
            d.sawFirst = en1 && (byteData == delim1);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            q <= '{sawFirst: 1'b0};
        else
            q <= d;
    end
endmodule : spk_delim_match

/* hdl/spk_idle_timer.sv */
`timescale 1ns/1ps
module spk_idle_timer import spk_pkg::*; #(
    parameter int W = SPK_TIMEOUT_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic msTick,
    input wire logic restart,
    input wire logic armed,
    input wire logic [W-1:0] limit,
    output logic expire
);
    typedef struct packed {
        logic [W-1:0] count;
    } spk_timer_s;

    spk_timer_s q;
    spk_timer_s d;

    always_comb
    begin
        d = q;
        // zero limit switches the timeout off altogether
        expire = armed && (limit != '0) && (q.count >= limit);
        if (restart || !armed)
            d.count = '0;
        else if (msTick && q.count < limit)
            d.count = q.count + 1'b1;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            q <= '{count: '0};
        else
            q <= d;
    end
endmodule : spk_idle_timer

/* hdl/spk_packer.sv */
// Operation
// - match count one closes buffer on a byte equal to either delimiter
// - match count two closes only on delimiter one then delimiter two
// - match count resets to two and matters only with both delimiters enabled
// - trailing selection ignored unless delimiter one is nonzero
// - with both delimiters on and match count two, trailing count starts after the pair
// - no-trailing setting releases the buffer on the completing byte
// - one-trailing setting releases after one more stored byte
// - two-trailing setting releases after two more stored bytes
// - trailing selection resets to none
// - timeout zero, the reset value, disables the idle timeout
// - nonzero timeout restarts per byte, closes non-empty buffer on expiry
// - packet length 1..1024 closes at that fill; zero means no limit
// - a full buffer is always sent and cleared
// - zero delimiter is unused; both zero forwards each byte at once
`timescale 1ns/1ps
module spk_packer import spk_pkg::*; #(
    parameter int DEPTH = SPK_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic msTick,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic rxReady,
    input wire logic frameReady,
    output logic frameValid,
    output spk_beat_s frameBeat,
    input wire logic [SPK_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [SPK_LEN_W-1:0] FULL_FILL = SPK_LEN_W'(DEPTH);

    typedef struct packed {
        spk_state_e st;
        logic [SPK_LEN_W-1:0] fill;
        logic [SPK_LEN_W-1:0] len;
        logic [SPK_LEN_W-1:0] ptr;
        logic trailOn;
        logic [1:0] trailLeft;
        logic rxReady;
        logic fValid;
        spk_beat_s beat;
        logic matchTwo;
        logic [1:0] trailSel;
        logic [7:0] delim1;
        logic [7:0] delim2;
        logic [SPK_TIMEOUT_W-1:0] timeout;
        logic [SPK_LEN_W-1:0] pktLen;
        logic [2:0] cause;
        logic [15:0] frames;
        logic [31:0] rdata;
    } spk_state_s;

    spk_state_s q;
    spk_state_s d;
    logic [7:0] mem [DEPTH];
    logic accept;
    logic closeNow;
    logic hit;
    logic expire;
    logic delimOn;
    logic [1:0] trailEff;
    logic [SPK_LEN_W-1:0] fillInc;

    assign accept = rxValid && q.rxReady;

    spk_delim_match u_match (
        .clk_sys(clk_sys),
        .rst(rst),
        .byteValid(accept),
        .byteData(rxData),
        .clear(closeNow),
        .delim1(q.delim1),
        .delim2(q.delim2),
        .matchTwo(q.matchTwo),
        .hit(hit)
    );

    spk_idle_timer #(.W(SPK_TIMEOUT_W)) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .msTick(msTick),
        .restart(accept || closeNow),
        .armed((q.st == SPK_ACCUM) && (q.fill != '0)),
        .limit(q.timeout),
        .expire(expire)
    );

    function automatic logic [1:0] trail_clamp(input logic [1:0] sel);
        // the unused code behaves as no trailing bytes
        if (sel == SPK_TRAIL_ONE || sel == SPK_TRAIL_TWO)
            return sel;
        return SPK_TRAIL_NONE;
    endfunction : trail_clamp

    always_comb
    begin
        d = q;
        closeNow = 1'b0;
        delimOn = (q.delim1 != 8'h00) || (q.delim2 != 8'h00);
        trailEff = (q.delim1 != 8'h00) ? trail_clamp(q.trailSel) : SPK_TRAIL_NONE;
        fillInc = q.fill + 1'b1;

        // register port: read data stands one cycle after the strobe
        d.rdata = 32'h0000_0000;
        if (regRd)
        begin
            case (regAddr)
                SPK_REG_CTRL:
                begin
                    d.rdata[SPK_CTRL_MATCH2_BIT] = q.matchTwo;
                    d.rdata[SPK_CTRL_TRAIL_LSB +: 2] = q.trailSel;
                end
                SPK_REG_DELIM:
                begin
                    d.rdata[SPK_DELIM1_LSB +: 8] = q.delim1;
                    d.rdata[SPK_DELIM2_LSB +: 8] = q.delim2;
                end
                SPK_REG_TIMEOUT:
                    d.rdata[SPK_TIMEOUT_W-1:0] = q.timeout;
                SPK_REG_PKTLEN:
                    d.rdata[SPK_LEN_W-1:0] = q.pktLen;
                SPK_REG_STATUS:
                begin
                    d.rdata[SPK_LEN_W-1:0] = q.fill;
                    d.rdata[SPK_STATUS_DRAIN_BIT] = (q.st == SPK_DRAIN);
                    d.rdata[SPK_STATUS_CAUSE_LSB +: 3] = q.cause;
                end
                SPK_REG_FRAMES:
                    d.rdata[15:0] = q.frames;
                default:
                    d.rdata = 32'h0000_0000;
            endcase
        end
        if (regWr)
        begin
            case (regAddr)
                SPK_REG_CTRL:
                begin
                    d.matchTwo = regWdata[SPK_CTRL_MATCH2_BIT];
                    d.trailSel = regWdata[SPK_CTRL_TRAIL_LSB +: 2];
                end
                SPK_REG_DELIM:
                begin
                    d.delim1 = regWdata[SPK_DELIM1_LSB +: 8];
                    d.delim2 = regWdata[SPK_DELIM2_LSB +: 8];
                end
                SPK_REG_TIMEOUT:
                    d.timeout = regWdata[SPK_TIMEOUT_W-1:0];
                SPK_REG_PKTLEN:
                    d.pktLen = regWdata[SPK_LEN_W-1:0];
                default:
                    d.frames = q.frames;
            endcase
        end

        case (q.st)
            SPK_ACCUM:
            begin
                if (accept)
                begin
                    d.fill = fillInc;
                    if (!delimOn)
                    begin
                        closeNow = 1'b1;
                        d.cause = SPK_CAUSE_PASS;
                    end
                    else if (q.trailOn)
                    begin
                        // delimiter hits inside the trailing bytes are plain data
                        if (q.trailLeft == 2'h1)
                        begin
                            closeNow = 1'b1;
                            d.cause = SPK_CAUSE_DELIM;
                        end
                        else
                            d.trailLeft = q.trailLeft - 2'h1;
                    end
                    else if (hit)
                    begin
                        if (trailEff == SPK_TRAIL_NONE)
                        begin
                            closeNow = 1'b1;
                            d.cause = SPK_CAUSE_DELIM;
                        end
                        else
                        begin
                            d.trailOn = 1'b1;
                            d.trailLeft = trailEff;
                        end
                    end
                    if (!closeNow && q.pktLen != '0 && fillInc == q.pktLen)
                    begin
                        closeNow = 1'b1;
                        d.cause = SPK_CAUSE_LENGTH;
                    end
                    if (!closeNow && fillInc == FULL_FILL)
                    begin
                        closeNow = 1'b1;
                        d.cause = SPK_CAUSE_FULL;
                    end
                end
                else if (expire)
                begin
                    closeNow = 1'b1;
                    d.cause = SPK_CAUSE_TIMEOUT;
                end
                if (closeNow)
                begin
                    d.st = SPK_DRAIN;
                    d.len = accept ? fillInc : q.fill;
                    d.ptr = '0;
                    d.trailOn = 1'b0;
                    d.trailLeft = 2'h0;
                    d.frames = q.frames + 16'h0001;
                end
                // no new byte is taken while a frame is being handed over
                d.rxReady = !closeNow;
            end
            SPK_DRAIN:
            begin
                if (!q.fValid || frameReady)
                begin
                    if (q.fValid && q.beat.last)
                    begin
                        d.fValid = 1'b0;
                        d.beat.last = 1'b0;
                        d.st = SPK_ACCUM;
                        d.fill = '0;
                        d.rxReady = 1'b1;
                    end
                    else
                    begin
                        d.fValid = 1'b1;
                        d.beat.data = mem[q.ptr[AW-1:0]];
                        d.beat.last = (q.ptr == q.len - 1'b1);
                        d.ptr = q.ptr + 1'b1;
                    end
                end
            end
            default:
            begin
                d.st = SPK_ACCUM;
                d.rxReady = 1'b1;
            end
        endcase
    end

    // buffer store kept out of the state struct so it can map to a RAM
    always_ff @(posedge clk_sys)
    begin
        if (accept)
            mem[q.fill[AW-1:0]] <= rxData;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= SPK_ACCUM;
            q.rxReady <= 1'b1;
            q.matchTwo <= SPK_RST_MATCH2;
            q.trailSel <= SPK_RST_TRAIL;
            q.delim1 <= SPK_RST_DELIM;
            q.delim2 <= SPK_RST_DELIM;
            q.timeout <= SPK_RST_TIMEOUT;
            q.pktLen <= SPK_RST_PKTLEN;
            q.cause <= SPK_CAUSE_NONE;
        end
        else
            q <= d;
    end

    assign rxReady = q.rxReady;
    assign frameValid = q.fValid;
    assign frameBeat = q.beat;
    assign regRdata = q.rdata;
endmodule : spk_packer

/* test/spk_packer_properties.sv */
`timescale 1ns/1ps
module spk_packer_properties import spk_pkg::*; #(
    parameter int DEPTH = SPK_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxReady,
    input wire logic frameReady,
    input wire logic frameValid,
    input wire spk_beat_s frameBeat,
    input wire logic [SPK_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr
);
    logic [7:0] d1;
    logic [7:0] d2;
    logic [2:0] ctl;
    logic take;
    logic dHit;
    // shadow of the setup; updated on the same edge as the packer registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            d1 <= SPK_RST_DELIM;
            d2 <= SPK_RST_DELIM;
            ctl <= {SPK_RST_TRAIL, SPK_RST_MATCH2};
        end
        else if (regWr && regAddr == SPK_REG_DELIM)
        begin
            d1 <= regWdata[7:0];
            d2 <= regWdata[15:8];
        end
        else if (regWr && regAddr == SPK_REG_CTRL)
        begin
            ctl <= regWdata[2:0];
        end
    end
    assign take = rxValid && rxReady;
    assign dHit = d1 != 8'h00 && (rxData == d1 || (d2 != 8'h00 && rxData == d2));
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_close;
        !rxReady ##1 frameValid;
    endsequence
    AST_MATCH_ONE: assert property (take && ctl == 3'h0 && dHit |=> s_close)
        else $error("single delimiter left buffer open");
    AST_PASS_BYTE: assert property (take && d1 == 8'h00 && d2 == 8'h00 |=> s_close)
        else $error("byte not forwarded at once");
    AST_BEAT_HOLD: assert property (frameValid && !frameReady |=> frameValid && $stable(frameBeat))
        else $error("beat changed while stalled");
    AST_LAST_END: assert property (frameValid && frameReady && frameBeat.last |=> !frameValid && rxReady)
        else $error("no fresh buffer after last beat");
    AST_BEAT_RUN: assert property (frameValid && frameReady && !frameBeat.last |=> frameValid)
        else $error("frame broke before last beat");
    AST_DRAIN_STOP: assert property (frameValid |-> !rxReady)
        else $error("byte taken while draining");
    AST_OPEN_ORDER: assert property ($rose(frameValid) |-> $past(!rxReady))
        else $error("frame opened without close");
    AST_RESET_STATE: assert property (disable iff (1'b0) $past(rst) |-> rxReady && !frameValid)
        else $error("state not cleared by reset");
endmodule : spk_packer_properties
bind spk_packer spk_packer_properties #(.DEPTH(DEPTH)) chk_u (
    .clk_sys(clk_sys),
    .rst(rst),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxReady(rxReady),
    .frameReady(frameReady),
    .frameValid(frameValid),
    .frameBeat(frameBeat),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr)
);

/* test/spk_frame_sink.sv */
`timescale 1ns/1ps
module spk_frame_sink import spk_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    input wire logic frameValid,
    input wire spk_beat_s frameBeat,
    output logic frameReady
);
    logic [8:0] beats[$];
    // slow mode stalls every other cycle so beats must hold
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            frameReady <= 1'b0;
        end
        else
        begin
            frameReady <= !slow || !frameReady;
            if (frameValid && frameReady)
            begin
                beats.push_back(frameBeat);
            end
        end
    end
endmodule : spk_frame_sink

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
    import spk_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic msTick = 1'b0;
    logic rxValid = 1'b0;
    logic [7:0] rxData = 8'h00;
    logic rxReady;
    logic frameReady;
    logic frameValid;
    spk_beat_s frameBeat;
    logic slow = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    int n_fail = 0;
    int checked = 0;
    always #2 clk_sys = ~clk_sys;
    // small depth so the full-buffer case stays short
    spk_packer #(.DEPTH(8)) dut_u (
        .clk_sys(clk_sys),
        .rst(rst),
        .msTick(msTick),
        .rxValid(rxValid),
        .rxData(rxData),
        .rxReady(rxReady),
        .frameReady(frameReady),
        .frameValid(frameValid),
        .frameBeat(frameBeat),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWr(regWr),
        .regRd(regRd),
        .regRdata(regRdata)
    );
    spk_frame_sink sink_u (
        .clk_sys(clk_sys),
        .rst(rst),
        .slow(slow),
        .frameValid(frameValid),
        .frameBeat(frameBeat),
        .frameReady(frameReady)
    );
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic hang(input string name);
        n_fail++;
        $display("[ERR] %s expected done seen timeout", name);
        test_done();
    endtask : hang
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        chk(name, exp, regRdata);
    endtask : rdchk
    task automatic send(input logic [7:0] bs[$]);
        int n;
        @(posedge clk_sys);
        foreach (bs[i])
        begin
            rxValid <= 1'b1;
            rxData <= bs[i];
            n = 0;
            do
            begin
                @(posedge clk_sys);
                n++;
            end
            while (rxReady !== 1'b1 && n < 200);
            if (n >= 200)
                hang("rx");
        end
        rxValid <= 1'b0;
    endtask : send
    task automatic frame(input string name, input logic [7:0] bs[$]);
        int n;
        n = 0;
        while (sink_u.beats.size() < bs.size() && n < 500)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 500)
            hang(name);
        repeat (4) @(posedge clk_sys);
        chk(name, bs.size(), sink_u.beats.size());
        foreach (bs[i])
            chk(name, {bs[i], i == bs.size() - 1}, sink_u.beats[i]);
        sink_u.beats.delete();
    endtask : frame
    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge clk_sys);
            msTick <= 1'b1;
            @(posedge clk_sys);
            msTick <= 1'b0;
        end
    endtask : tick
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk("ctrl", SPK_REG_CTRL, 32'h1);
        rdchk("timeout", SPK_REG_TIMEOUT, 32'h0);
        rdchk("pktlen", SPK_REG_PKTLEN, 32'h0);
        wr(SPK_REG_FRAMES, 32'h55);
        rdchk("frames", SPK_REG_FRAMES, 32'h0);
        rdchk("unmapped", 4'hf, 32'h0);
        wr(SPK_REG_CTRL, 32'h2);
        send('{8'h11});
        frame("pass", '{8'h11});
        send('{8'h22});
        frame("pass", '{8'h22});
        wr(SPK_REG_DELIM, 32'h0a0d);
        wr(SPK_REG_CTRL, 32'h0);
        send('{8'h41, 8'h0a});
        frame("one", '{8'h41, 8'h0a});
        send('{8'h0d});
        frame("one", '{8'h0d});
        wr(SPK_REG_CTRL, 32'h1);
        send('{8'h0a, 8'h0d, 8'h43, 8'h0d, 8'h0a});
        frame("two", '{8'h0a, 8'h0d, 8'h43, 8'h0d, 8'h0a});
        wr(SPK_REG_CTRL, 32'h3);
        send('{8'h0d, 8'h0a, 8'h55});
        frame("trail1", '{8'h0d, 8'h0a, 8'h55});
        slow <= 1'b1;
        wr(SPK_REG_CTRL, 32'h4);
        send('{8'h0d, 8'h66, 8'h77});
        frame("trail2", '{8'h0d, 8'h66, 8'h77});
        wr(SPK_REG_CTRL, 32'h0);
        wr(SPK_REG_DELIM, 32'h0d);
        wr(SPK_REG_TIMEOUT, 32'h3);
        send('{8'h88});
        tick(2);
        repeat (4) @(posedge clk_sys);
        chk("idle", 32'h0, sink_u.beats.size());
        tick(1);
        frame("idle", '{8'h88});
        wr(SPK_REG_TIMEOUT, 32'h0);
        send('{8'h99});
        tick(5);
        chk("notimeout", 32'h0, sink_u.beats.size());
        send('{8'h0d});
        frame("notimeout", '{8'h99, 8'h0d});
        wr(SPK_REG_PKTLEN, 32'h3);
        send('{8'ha1, 8'ha2, 8'ha3});
        frame("length", '{8'ha1, 8'ha2, 8'ha3});
        wr(SPK_REG_PKTLEN, 32'h0);
        send('{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7});
        frame("full", '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7});
        rdchk("status", SPK_REG_STATUS, 32'h0040_0000);
        rdchk("frames", SPK_REG_FRAMES, 32'hb);
        test_done();
    end
endmodule : tb
